// file: design/dptpm_pkg.sv
/*
 * Constants, carrier types and helper functions of the dual timer pin mux:
 * register addresses, reset values, pin positions and the state record.
 * Assumes an 8-bit register address on a plain strobe port.
 */
// Operation
// - First port direction bits: 0 makes the pin input, 1 output.
// - Reset clears first port direction and function select; all pins inputs.
// - Reset presets both data latches to ones while pins stay inputs.
// - First port pins 2,5,6,7 drive timers 0-3 when function and direction set.
// - First port pins 0,1,3,4 feed captures and interrupts 5-8 as inputs.
// - First port function bit 0 keeps plain port use; 1 enables alternate.
// - Second port direction bits: 0 makes the pin input, 1 output.
// - Reset clears second port direction and function select; all pins inputs.
// - Second port pins 0-5 drive timers 4-9 when function and direction set.
// - Second port pins 6,7 feed timer ten captures as function inputs.
// - Second port function bit 0 keeps plain port use; 1 enables alternate.
package dptpm_pkg;

    localparam int unsigned PORT_W = 8;
    localparam int unsigned ADDR_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_A_DATA = 8'h43;
    localparam logic [ADDR_W-1:0] ADDR_A_DIR  = 8'h47;
    localparam logic [ADDR_W-1:0] ADDR_A_FUNC = 8'h4b;
    localparam logic [ADDR_W-1:0] ADDR_B_DATA = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_B_DIR  = 8'h54;
    localparam logic [ADDR_W-1:0] ADDR_B_FUNC = 8'h58;

    localparam logic [PORT_W-1:0] DATA_RST    = 8'hff;
    localparam logic [PORT_W-1:0] DIR_RST     = 8'h00;
    localparam logic [PORT_W-1:0] FUNC_RST    = 8'h00;
    localparam logic [PORT_W-1:0] OE_N_IDLE   = 8'hff;
    localparam logic [PORT_W-1:0] RDATA_IDLE  = 8'h00;

    // Alternate pin sets
    localparam logic [PORT_W-1:0] A_OUT_MASK  = 8'he4;
    localparam logic [PORT_W-1:0] A_IN_MASK   = 8'h1b;
    localparam logic [PORT_W-1:0] B_OUT_MASK  = 8'h3f;
    localparam logic [PORT_W-1:0] B_IN_MASK   = 8'hc0;

    localparam int unsigned PA_T0_POS  = 2;
    localparam int unsigned PA_T1_POS  = 5;
    localparam int unsigned PA_T2_POS  = 6;
    localparam int unsigned PA_T3_POS  = 7;
    localparam int unsigned PA_IN0_POS = 0;
    localparam int unsigned PA_IN1_POS = 1;
    localparam int unsigned PA_IN2_POS = 3;
    localparam int unsigned PA_IN3_POS = 4;
    localparam int unsigned PB_T4_POS  = 0;
    localparam int unsigned PB_TMR_N   = 6;
    localparam int unsigned PB_IN0_POS = 6;
    localparam int unsigned PB_IN1_POS = 7;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_A_DATA, SEL_A_DIR, SEL_A_FUNC,
        SEL_B_DATA, SEL_B_DIR, SEL_B_FUNC
    } dptpm_sel_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [PORT_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } dptpm_bus_s;

    typedef struct packed {
        logic [PORT_W-1:0] data;
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] func;
    } dptpm_port_s;

    // Timer outputs: first = timers 0..3, second = timers 4..9
    typedef struct packed {
        logic [3:0] first;
        logic [5:0] second;
    } dptpm_tmr_s;

    // first_cap = t0 in0, t0 in1, t1 in0, t1 in1; ext_irq = 5..8
    typedef struct packed {
        logic [3:0] first_cap;
        logic [3:0] ext_irq;
        logic [1:0] second_cap;
    } dptpm_alt_s;

    typedef struct packed {
        dptpm_port_s       port_a;
        dptpm_port_s       port_b;
        logic [PORT_W-1:0] pin_a;
        logic [PORT_W-1:0] oe_n_a;
        logic [PORT_W-1:0] pin_b;
        logic [PORT_W-1:0] oe_n_b;
        logic [PORT_W-1:0] rdata;
        dptpm_alt_s        alt;
    } dptpm_state_s;

    localparam dptpm_state_s STATE_RST = '{
        port_a: '{data: DATA_RST, dir: DIR_RST, func: FUNC_RST},
        port_b: '{data: DATA_RST, dir: DIR_RST, func: FUNC_RST},
        pin_a:  DATA_RST,
        oe_n_a: OE_N_IDLE,
        pin_b:  DATA_RST,
        oe_n_b: OE_N_IDLE,
        rdata:  RDATA_IDLE,
        alt:    '0
    };

    function automatic dptpm_sel_e dptpm_decode(logic [ADDR_W-1:0] a);
        if (a == ADDR_A_DATA) return SEL_A_DATA;
        else if (a == ADDR_A_DIR) return SEL_A_DIR;
        else if (a == ADDR_A_FUNC) return SEL_A_FUNC;
        else if (a == ADDR_B_DATA) return SEL_B_DATA;
        else if (a == ADDR_B_DIR) return SEL_B_DIR;
        else if (a == ADDR_B_FUNC) return SEL_B_FUNC;
        else return SEL_NONE;
    endfunction : dptpm_decode

    // Port view seen by software: pin for inputs, latch for outputs
    function automatic logic [PORT_W-1:0] dptpm_view(dptpm_port_s p,
                                                     logic [PORT_W-1:0] pins);
        return (p.dir & p.data) | (~p.dir & pins);
    endfunction : dptpm_view

endpackage : dptpm_pkg

// file: design/dptpm_pin_mux.sv
/*
 * Pin multiplexer of one 8-bit port: next pin level, enable and the
 * alternate input view. Purely combinational; the caller registers it.
 * Assumes pin inputs synchronous to the clock.
 */
`timescale 1ns/1ps
module dptpm_pin_mux
    import dptpm_pkg::*;
#(
    parameter logic [PORT_W-1:0] OUT_MASK = '0,
    parameter logic [PORT_W-1:0] IN_MASK  = '0
) (
    input  wire dptpm_port_s       port_i,
    input  wire logic [PORT_W-1:0] pins_i,
    input  wire logic [PORT_W-1:0] tmr_i,
    output logic      [PORT_W-1:0] pin_o,
    output logic      [PORT_W-1:0] oe_n_o,
    output logic      [PORT_W-1:0] alt_in_o
);

    if ((OUT_MASK & IN_MASK) != '0) begin : g_bad_mask
        $error("Pin cannot be both alternate output and input");
    end

    logic [PORT_W-1:0] alt_drv;

    always_comb begin
        alt_drv  = port_i.func & port_i.dir & OUT_MASK;
        pin_o    = (alt_drv & tmr_i) | (~alt_drv & port_i.data);
        oe_n_o   = ~port_i.dir;
        alt_in_o = port_i.func & ~port_i.dir & IN_MASK & pins_i;
    end

endmodule : dptpm_pin_mux

// file: design/dptpm_rd_mux.sv
/*
 * Read data selection for the register port of the pin mux.
 * Assumes the decoded select and both port views are valid this cycle.
 */
`timescale 1ns/1ps
module dptpm_rd_mux
    import dptpm_pkg::*;
(
    input  wire dptpm_sel_e        sel_i,
    input  wire dptpm_port_s       port_a_i,
    input  wire dptpm_port_s       port_b_i,
    input  wire logic [PORT_W-1:0] view_a_i,
    input  wire logic [PORT_W-1:0] view_b_i,
    output logic      [PORT_W-1:0] rdata_o
);

    always_comb begin
        case (sel_i)
            SEL_A_DATA: rdata_o = view_a_i;
            SEL_A_DIR:  rdata_o = port_a_i.dir;
            SEL_A_FUNC: rdata_o = port_a_i.func;
            SEL_B_DATA: rdata_o = view_b_i;
            SEL_B_DIR:  rdata_o = port_b_i.dir;
            SEL_B_FUNC: rdata_o = port_b_i.func;
            default:    rdata_o = RDATA_IDLE;
        endcase
    end

endmodule : dptpm_rd_mux

// file: design/dptpm_top.sv
/*
 * Two 8-bit general-purpose ports with timer and interrupt pin functions.
 * Holds the data, direction and function registers, the registered pin
 * drivers and the registered alternate inputs toward timers and the
 * interrupt controller.
 * Assumes synchronous pins, one clock, a master that never waits and
 * an external pad that resolves level from the active-low enables.
 */
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
module dptpm_top
    import dptpm_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    input  wire dptpm_bus_s        bus_i,
    output logic      [PORT_W-1:0] rdata_o,
    input  wire logic [PORT_W-1:0] pins_a_i,
    output logic      [PORT_W-1:0] pins_a_o,
    output logic      [PORT_W-1:0] pins_a_oe_n_o,
    input  wire logic [PORT_W-1:0] pins_b_i,
    output logic      [PORT_W-1:0] pins_b_o,
    output logic      [PORT_W-1:0] pins_b_oe_n_o,
    input  wire dptpm_tmr_s        tmr_i,
    output dptpm_alt_s             alt_o
);

    localparam int unsigned PB_T9_POS = PB_T4_POS + PB_TMR_N - 1;

    dptpm_state_s      st_q;
    dptpm_state_s      st_d;
    dptpm_sel_e        sel;
    logic [PORT_W-1:0] view_a;
    logic [PORT_W-1:0] view_b;
    logic [PORT_W-1:0] rd_val;
    logic [PORT_W-1:0] tmr_a;
    logic [PORT_W-1:0] tmr_b;
    logic [PORT_W-1:0] pin_a_d;
    logic [PORT_W-1:0] oe_n_a_d;
    logic [PORT_W-1:0] alt_a;
    logic [PORT_W-1:0] pin_b_d;
    logic [PORT_W-1:0] oe_n_b_d;
    logic [PORT_W-1:0] alt_b;

    // Timer outputs spread onto their pin positions
    always_comb begin
        tmr_a = '0;
        tmr_a[PA_T0_POS] = tmr_i.first[0];
        tmr_a[PA_T1_POS] = tmr_i.first[1];
        tmr_a[PA_T2_POS] = tmr_i.first[2];
        tmr_a[PA_T3_POS] = tmr_i.first[3];
        tmr_b = '0;
        for (int i = 0; i < PB_TMR_N; i++) begin
            tmr_b[PB_T4_POS + i] = tmr_i.second[i];
        end
    end

    assign sel    = dptpm_decode(bus_i.addr);
    assign view_a = dptpm_view(st_q.port_a, pins_a_i);
    assign view_b = dptpm_view(st_q.port_b, pins_b_i);

    dptpm_pin_mux #(
        .OUT_MASK (A_OUT_MASK),
        .IN_MASK  (A_IN_MASK)
    ) u_mux_a (
        .port_i   (st_q.port_a),
        .pins_i   (pins_a_i),
        .tmr_i    (tmr_a),
        .pin_o    (pin_a_d),
        .oe_n_o   (oe_n_a_d),
        .alt_in_o (alt_a)
    );

    dptpm_pin_mux #(
        .OUT_MASK (B_OUT_MASK),
        .IN_MASK  (B_IN_MASK)
    ) u_mux_b (
        .port_i   (st_q.port_b),
        .pins_i   (pins_b_i),
        .tmr_i    (tmr_b),
        .pin_o    (pin_b_d),
        .oe_n_o   (oe_n_b_d),
        .alt_in_o (alt_b)
    );

    dptpm_rd_mux u_rd (
        .sel_i    (sel),
        .port_a_i (st_q.port_a),
        .port_b_i (st_q.port_b),
        .view_a_i (view_a),
        .view_b_i (view_b),
        .rdata_o  (rd_val)
    );

    always_comb begin
        st_d = st_q;
        if (ce_i) begin
            if (bus_i.wr) begin
                case (sel)
                    SEL_A_DATA: st_d.port_a.data = bus_i.wdata;
                    SEL_A_DIR:  st_d.port_a.dir  = bus_i.wdata;
                    SEL_A_FUNC: st_d.port_a.func = bus_i.wdata;
                    SEL_B_DATA: st_d.port_b.data = bus_i.wdata;
                    SEL_B_DIR:  st_d.port_b.dir  = bus_i.wdata;
                    SEL_B_FUNC: st_d.port_b.func = bus_i.wdata;
                    default: ;
                endcase
            end
            // Read data only in the cycle after the strobe
            st_d.rdata  = bus_i.rd ? rd_val : RDATA_IDLE;
            st_d.pin_a  = pin_a_d;
            st_d.oe_n_a = oe_n_a_d;
            st_d.pin_b  = pin_b_d;
            st_d.oe_n_b = oe_n_b_d;
            // Same pin feeds capture and interrupt; consumers choose
            st_d.alt.first_cap = {alt_a[PA_IN3_POS], alt_a[PA_IN2_POS],
                                  alt_a[PA_IN1_POS], alt_a[PA_IN0_POS]};
            st_d.alt.ext_irq   = {alt_a[PA_IN3_POS], alt_a[PA_IN2_POS],
                                  alt_a[PA_IN1_POS], alt_a[PA_IN0_POS]};
            st_d.alt.second_cap = {alt_b[PB_IN1_POS], alt_b[PB_IN0_POS]};
        end
        if (srst_i) begin
            st_d = STATE_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        st_q <= st_d;
    end

    assign rdata_o       = st_q.rdata;
    assign pins_a_o      = st_q.pin_a;
    assign pins_a_oe_n_o = st_q.oe_n_a;
    assign pins_b_o      = st_q.pin_b;
    assign pins_b_oe_n_o = st_q.oe_n_b;
    assign alt_o         = st_q.alt;

    // Checks against the registered state

    reset_values_a: assert property (
        @(posedge clk_i)
        srst_i |=> st_q.port_a.dir == DIR_RST && st_q.port_a.func == FUNC_RST
            && st_q.port_b.dir == DIR_RST && st_q.port_b.func == FUNC_RST
            && st_q.port_a.data == DATA_RST && st_q.port_b.data == DATA_RST
            && pins_a_oe_n_o == OE_N_IDLE && pins_b_oe_n_o == OE_N_IDLE)
        else $error("Registers not at reset values after reset");

    a_dir_write_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && bus_i.wr && bus_i.addr == ADDR_A_DIR
            |=> st_q.port_a.dir == $past(bus_i.wdata)
                ##1 (!ce_i || pins_a_oe_n_o == ~$past(bus_i.wdata, 2)))
        else $error("First port direction write not applied to pins");

    b_dir_write_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && bus_i.wr && bus_i.addr == ADDR_B_DIR
            |=> st_q.port_b.dir == $past(bus_i.wdata)
                ##1 (!ce_i || pins_b_oe_n_o == ~$past(bus_i.wdata, 2)))
        else $error("Second port direction write not applied to pins");

    a_timer_out_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && st_q.port_a.func[PA_T0_POS] && st_q.port_a.dir[PA_T0_POS]
            |=> pins_a_o[PA_T0_POS] == $past(tmr_i.first[0])
                && !pins_a_oe_n_o[PA_T0_POS])
        else $error("Timer zero output not on its pin");

    a_timer3_out_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && st_q.port_a.func[PA_T3_POS] && st_q.port_a.dir[PA_T3_POS]
            |=> pins_a_o[PA_T3_POS] == $past(tmr_i.first[3]))
        else $error("Timer three output not on its pin");

    a_capture_in_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && st_q.port_a.func[PA_IN2_POS] && !st_q.port_a.dir[PA_IN2_POS]
            |=> alt_o.first_cap[2] == $past(pins_a_i[PA_IN2_POS])
                && alt_o.ext_irq[2] == $past(pins_a_i[PA_IN2_POS]))
        else $error("Capture or interrupt input not fed from pin");

    a_plain_port_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && !st_q.port_a.func[PA_T1_POS] && st_q.port_a.dir[PA_T1_POS]
            |=> pins_a_o[PA_T1_POS] == $past(st_q.port_a.data[PA_T1_POS])
                && !alt_o.first_cap[0] == !$past(st_q.port_a.func[PA_IN0_POS]
                    && !st_q.port_a.dir[PA_IN0_POS] && pins_a_i[PA_IN0_POS]))
        else $error("Plain first port pin not driven from latch");

    b_timer_out_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && st_q.port_b.func[PB_T9_POS] && st_q.port_b.dir[PB_T9_POS]
            |=> pins_b_o[PB_T9_POS] == $past(tmr_i.second[PB_TMR_N-1]))
        else $error("Timer nine output not on its pin");

    b_capture_in_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i |=> alt_o.second_cap[1] == $past(st_q.port_b.func[PB_IN1_POS]
            && !st_q.port_b.dir[PB_IN1_POS] && pins_b_i[PB_IN1_POS]))
        else $error("Timer ten capture input wrong");

    b_plain_port_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && !st_q.port_b.func[PB_T4_POS] && st_q.port_b.dir[PB_T4_POS]
            |=> pins_b_o[PB_T4_POS] == $past(st_q.port_b.data[PB_T4_POS]))
        else $error("Plain second port pin not driven from latch");

    read_view_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && bus_i.rd && bus_i.addr == ADDR_A_DATA
            |=> rdata_o == (($past(st_q.port_a.dir) & $past(st_q.port_a.data))
                | (~$past(st_q.port_a.dir) & $past(pins_a_i))))
        else $error("Data read does not mix pins and latch");

    latch_write_a: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ce_i && bus_i.wr && bus_i.addr == ADDR_B_DATA
            |=> st_q.port_b.data == $past(bus_i.wdata))
        else $error("Data write not stored in latch");

    read_idle_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ce_i && !bus_i.rd |=> rdata_o == RDATA_IDLE)
        else $error("Read data present without a read strobe");

    state_freeze_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !ce_i |=> $stable(st_q))
        else $error("State moved while clock enable low");

endmodule : dptpm_top

// file: test/dptpm_board_model.sv
/*
 * Board seen from the pins of both ports: a pin the device does not
 * drive follows the board's own level, a driven pin follows the device.
 * Assumes active-low enables and board levels supplied by the bench.
 */
`timescale 1ns/1ps
module dptpm_board_model
    import dptpm_pkg::*;
(
    input  wire logic [PORT_W-1:0] drive_a_i,
    input  wire logic [PORT_W-1:0] drive_b_i,
    input  wire logic [PORT_W-1:0] dev_a_i,
    input  wire logic [PORT_W-1:0] dev_a_oe_n_i,
    input  wire logic [PORT_W-1:0] dev_b_i,
    input  wire logic [PORT_W-1:0] dev_b_oe_n_i,
    output logic      [PORT_W-1:0] pins_a_o,
    output logic      [PORT_W-1:0] pins_b_o
);
    // Shared input pins reach every consumer; choice is theirs
    assign pins_a_o = (dev_a_oe_n_i & drive_a_i)
                    | (~dev_a_oe_n_i & dev_a_i);
    assign pins_b_o = (dev_b_oe_n_i & drive_b_i)
                    | (~dev_b_oe_n_i & dev_b_i);
endmodule : dptpm_board_model

// file: test/dual_port_timer_pin_mux_tb.sv
/*
 * Self-checking bench of the dual port timer pin mux: register access,
 * reset values, timer outputs, alternate inputs, refusals and clock enable.
 * Assumes the board model and the design package.
 */
`timescale 1ns/1ps
module dual_port_timer_pin_mux_tb
    import dptpm_pkg::*;
();
    logic              clk_i  = 1'b0;
    logic              srst_i = 1'b1;
    logic              ce_i   = 1'b1;
    dptpm_bus_s        bus    = '0;
    dptpm_tmr_s        tmr    = '0;
    logic [PORT_W-1:0] drv_a  = 8'h5a;
    logic [PORT_W-1:0] drv_b  = 8'ha5;
    logic [PORT_W-1:0] rdata, pa_o, pa_oe_n, pa_i, pb_o, pb_oe_n, pb_i;
    logic [PORT_W-1:0] tmr_a_exp, cap_a_exp, cap_b_exp;
    dptpm_alt_s        alt;
    int                failures    = 0;
    int                comparisons = 0;
    logic [9:0]        tp [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
    logic [7:0]        dp [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};

    always #2.5 clk_i = ~clk_i;

    // Expected pin and capture levels from the bench's own stimulus
    assign tmr_a_exp = {tmr.first[3:1], 2'b11, tmr.first[0], 2'b11};
    assign cap_a_exp = {4'h0, drv_a[4:3], drv_a[1:0]};
    assign cap_b_exp = {6'h00, drv_b[7:6]};

    dptpm_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .bus_i(bus), .rdata_o(rdata), .pins_a_i(pa_i), .pins_a_o(pa_o),
        .pins_a_oe_n_o(pa_oe_n), .pins_b_i(pb_i), .pins_b_o(pb_o),
        .pins_b_oe_n_o(pb_oe_n), .tmr_i(tmr), .alt_o(alt));

    dptpm_board_model board_u (.drive_a_i(drv_a), .drive_b_i(drv_b),
        .dev_a_i(pa_o), .dev_a_oe_n_i(pa_oe_n), .dev_b_i(pb_o),
        .dev_b_oe_n_i(pb_oe_n), .pins_a_o(pa_i), .pins_b_o(pb_i));

    task automatic close_out;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus <= '0;
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [7:0] exp);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1;
        chk(what, rdata, exp);
    endtask : rd_chk

    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic chk_reset;
        rd_chk("a data", ADDR_A_DATA, drv_a);
        rd_chk("a dir", ADDR_A_DIR, 8'h00);
        rd_chk("a func", ADDR_A_FUNC, 8'h00);
        rd_chk("b data", ADDR_B_DATA, drv_b);
        rd_chk("b dir", ADDR_B_DIR, 8'h00);
        rd_chk("b func", ADDR_B_FUNC, 8'h00);
        chk("a oe_n", pa_oe_n, 8'hff);
        chk("b oe_n", pb_oe_n, 8'hff);
        chk("a pins", pa_o, 8'hff);
        chk("b pins", pb_o, 8'hff);
    endtask : chk_reset

    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        chk_reset();
        // Latch preset becomes visible once pins turn to outputs
        wr(ADDR_B_DIR, 8'hff);
        settle();
        chk("b latch", pb_o, 8'hff);
        chk("b oe_n out", pb_oe_n, 8'h00);
        wr(ADDR_A_DIR, 8'h0f);
        wr(ADDR_A_DATA, 8'h33);
        settle();
        chk("a oe_n mixed", pa_oe_n, 8'hf0);
        chk("a pins mixed", pa_o, 8'h33);
        rd_chk("a data mixed", ADDR_A_DATA, 8'h53);
        // Timer outputs on both ports
        wr(ADDR_A_DATA, 8'h1b);
        wr(ADDR_A_DIR, 8'hff);
        wr(ADDR_A_FUNC, 8'hff);
        wr(ADDR_B_DATA, 8'h80);
        wr(ADDR_B_DIR, 8'h3f);
        wr(ADDR_B_FUNC, 8'hff);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            tmr <= tp[i];
            settle();
            chk("a timer pins", pa_o, tmr_a_exp);
            chk("b timer pins", pb_o, {2'b10, tmr.second});
        end
        chk("b oe_n timers", pb_oe_n, 8'hc0);
        chk("cap when output", {4'h0, alt.first_cap}, 8'h00);
        rd_chk("a func", ADDR_A_FUNC, 8'hff);
        // Alternate inputs; irq bits set here only to observe routing
        wr(ADDR_A_DIR, 8'h00);
        wr(ADDR_B_DIR, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            drv_a <= dp[i];
            drv_b <= ~dp[i];
            settle();
            chk("first cap", {4'h0, alt.first_cap}, cap_a_exp);
            chk("ext irq", {4'h0, alt.ext_irq}, cap_a_exp);
            chk("second cap", {6'h00, alt.second_cap}, cap_b_exp);
        end
        chk("a func input pins", pa_oe_n, 8'hff);
        wr(ADDR_A_FUNC, 8'h00);
        wr(ADDR_B_FUNC, 8'h3f);
        settle();
        chk("first cap off", {4'h0, alt.first_cap}, 8'h00);
        chk("ext irq off", {4'h0, alt.ext_irq}, 8'h00);
        chk("second cap off", {6'h00, alt.second_cap}, 8'h00);
        rd_chk("a data input", ADDR_A_DATA, drv_a);
        // Unmapped place and frozen clock enable
        wr(8'h48, 8'hff);
        rd_chk("unmapped", 8'h48, 8'h00);
        rd_chk("a dir kept", ADDR_A_DIR, 8'h00);
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(ADDR_A_DIR, 8'h55);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rd_chk("a dir frozen", ADDR_A_DIR, 8'h00);
        rd_chk("b func kept", ADDR_B_FUNC, 8'h3f);
        // Second reset in mid-run
        wr(ADDR_A_DIR, 8'hff);
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        chk_reset();
        close_out();
    end

    initial begin
        #20000;
        failures++;
        close_out();
    end
endmodule : dual_port_timer_pin_mux_tb
